// ### verilog/hostlink_pkg.sv
// shared constants, types and frame helpers for the addressed ascii command link
package hostlink_pkg;

  // ---------------------------------------------------------------
  // characters on the line
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_AT   = 8'h40;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_ENQ  = 8'h05;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_A    = 8'h41;
  localparam logic [7:0] CH_F    = 8'h46;
  localparam logic [7:0] HEX_ALPHA_BIAS = 8'h37;

  // ---------------------------------------------------------------
  // frame geometry, modes and error headers
  // ---------------------------------------------------------------
  localparam int         DATA_MAX      = 8;
  localparam int         RX_DEPTH      = 20;
  localparam int         TX_DEPTH      = 20;
  localparam logic [4:0] RX_FULL       = 5'h14;
  localparam logic [4:0] MP_MIN_LEN    = 5'h07;
  localparam logic [4:0] PP_MIN_LEN    = 5'h02;
  localparam logic [4:0] MP_OVERHEAD   = 5'h07;
  localparam logic [4:0] PP_OVERHEAD   = 5'h02;
  localparam logic [4:0] MP_DATA_OFS   = 5'h05;
  localparam logic [4:0] PP_DATA_OFS   = 5'h02;
  localparam logic [4:0] DATA_MAX_LEN  = 5'h08;
  localparam logic [4:0] FCS_BACK      = 5'h02;
  localparam logic [4:0] FCS_FROM_END  = 5'h04;
  localparam logic [3:0] PROTO_NATIVE  = 4'h5;
  localparam logic [15:0] HDR_FRAME_ERR = 16'h4531;
  localparam logic [15:0] HDR_CMD_ERR   = 16'h4530;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RESP_TIMEOUT_NS = 1000000;
  // longest wait, rounded down to whole cycles
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef logic [DATA_MAX-1:0][7:0] data_t;
  typedef logic [RX_DEPTH-1:0][7:0] rxbuf_t;

  typedef struct packed {
    logic [TX_DEPTH-1:0][7:0] chars;
    logic [4:0]               len;
  } frame_t;

  typedef struct packed {
    logic [15:0] hdr;
    data_t       data;
    logic [4:0]  len;
    logic [7:0]  id;
    logic        id_bad;
    logic        fcs_ok;
    logic        wild;
  } parsed_t;

  // nibble to upper-case ascii hex digit
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n > 4'h9) ? 8'({4'h0, n}) + HEX_ALPHA_BIAS : 8'({4'h0, n}) + CH_ZERO;
  endfunction

  // ascii hex digit to {bad, nibble}
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] t;
    t = 8'h00;
    if (c >= CH_ZERO && c <= CH_NINE) begin
      t = c - CH_ZERO;
      hex_val = {1'b0, t[3:0]};
    end else if (c >= CH_A && c <= CH_F) begin
      t = c - HEX_ALPHA_BIAS;
      hex_val = {1'b0, t[3:0]};
    end else begin
      hex_val = 5'h10;
    end
  endfunction

  // builds a whole frame; multi-point gets '@', id and a fresh check byte
  function automatic frame_t build_frame(input logic mp, input logic [7:0] id,
                                         input logic [15:0] hdr, input data_t data,
                                         input logic [4:0] len);
    frame_t     f;
    logic [7:0] x;
    int         n;
    f = '0;
    x = 8'h00;
    n = 0;
    if (mp) begin
      f.chars[0] = CH_AT;
      f.chars[1] = hex_char(id[7:4]);
      f.chars[2] = hex_char(id[3:0]);
      n = 3;
    end
    f.chars[n]   = hdr[15:8];
    f.chars[n+1] = hdr[7:0];
    n = n + 2;
    for (int i = 0; i < DATA_MAX; i++) begin
      if (i < int'(len)) begin
        f.chars[n] = data[i];
        n = n + 1;
      end
    end
    for (int i = 0; i < TX_DEPTH; i++) begin
      if (i < n) x = x ^ f.chars[i];
    end
    if (mp) begin
      f.chars[n]   = hex_char(x[7:4]);
      f.chars[n+1] = hex_char(x[3:0]);
      n = n + 2;
    end
    f.chars[n]   = CH_STAR;
    f.chars[n+1] = CH_CR;
    f.len = 5'(n + 2);
    return f;
  endfunction

  // splits a stored frame (terminator stripped); x is the xor of all stored chars
  function automatic parsed_t parse_frame(input rxbuf_t rx, input logic [4:0] cnt,
                                          input logic [7:0] x, input logic mp);
    parsed_t    p;
    logic [4:0] ofs;
    logic [4:0] f;
    logic [4:0] hi;
    logic [4:0] lo;
    logic [4:0] c1;
    logic [4:0] c0;
    p   = '0;
    ofs = mp ? MP_DATA_OFS : PP_DATA_OFS;
    f   = cnt - FCS_BACK;
    hi  = hex_val(rx[1]);
    lo  = hex_val(rx[2]);
    c1  = hex_val(rx[f]);
    c0  = hex_val(rx[f + 5'h01]);
    p.id     = {hi[3:0], lo[3:0]};
    p.id_bad = hi[4] | lo[4];
    p.hdr    = {rx[ofs - 5'h02], rx[ofs - 5'h01]};
    p.len    = mp ? cnt - MP_OVERHEAD : cnt - PP_OVERHEAD;
    for (int i = 0; i < DATA_MAX; i++) p.data[i] = rx[ofs + 5'(i)];
    p.wild   = (rx[f] == CH_ZERO) && (rx[f + 5'h01] == CH_ZERO);
    // the check field itself is taken back out of the running xor
    p.fcs_ok = !c1[4] && !c0[4] && ({c1[3:0], c0[3:0]} == (x ^ rx[f] ^ rx[f + 5'h01]));
    return p;
  endfunction

endpackage

// ### verilog/hostlink_if.sv
// character stream carrier between the master end and the responding end
`timescale 1ns/1ps
`default_nettype none
interface hostlink_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport device (input h2d_data, h2d_valid, d2h_ready,
                  output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid);
endinterface
`default_nettype wire

// ### verilog/hostlink_device.sv
// responding end: receives, checks and answers host link command frames
`timescale 1ns/1ps
`default_nettype none
module hostlink_device (
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // configuration
  input  wire logic [7:0]            DEV_ID_I,
  input  wire logic [3:0]            PROTO_SEL_I,
  // link towards the host
  hostlink_if.device                 link,
  // decoded command towards the user logic
  output logic                       CMD_VALID_O,
  output logic                       CMD_MP_O,
  output logic [15:0]                CMD_HDR_O,
  output hostlink_pkg::data_t        CMD_DATA_O,
  output logic [4:0]                 CMD_LEN_O,
  // user answer
  input  wire logic                  RSP_VALID_I,
  input  wire logic                  RSP_OK_I,
  input  wire hostlink_pkg::data_t   RSP_DATA_I,
  input  wire logic [4:0]            RSP_LEN_I,
  // events
  output logic                       FCS_ERR_O
);
  import hostlink_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_RX, S_CMD, S_TX} dstate_t;

  typedef struct packed {
    dstate_t     st;
    logic        mp;
    logic        star;
    logic        pp_next;
    rxbuf_t      rx;
    logic [4:0]  cnt;
    logic [7:0]  x;
    frame_t      tx;
    logic [4:0]  idx;
    logic [7:0]  out;
    logic [15:0] hdr;
    data_t       data;
    logic [4:0]  len;
    logic        fcs_err;
  } dev_t;

  dev_t       q;
  dev_t       d;
  parsed_t    p;
  frame_t     ld;
  logic       load;
  logic [7:0] c;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d         = q;
    d.fcs_err = 1'b0;
    load      = 1'b0;
    ld        = '0;
    c         = link.h2d_data;
    p         = parse_frame(q.rx, q.cnt, q.x, q.mp);
    case (q.st)
      S_IDLE, S_RX: begin
        if (link.h2d_valid) begin
          if (c == CH_AT) begin
            // a fresh '@' always restarts, even mid-frame
            d.st   = S_RX;
            d.mp   = 1'b1;
            d.star = 1'b0;
            d.rx   = '0;
            d.rx[0] = c;
            d.cnt  = 5'h01;
            d.x    = c;
          end else if (q.st == S_IDLE) begin
            if (c == CH_ENQ) begin
              // echo the enquiry, then wait for an unaddressed frame
              ld.chars[0] = CH_ENQ;
              ld.len      = 5'h01;
              load        = 1'b1;
              d.pp_next   = 1'b1;
            end
          end else if (q.star) begin
            if (c == CH_CR) begin
              // whole terminator seen: judge the frame now
              if (q.mp) begin
                if (q.cnt < MP_MIN_LEN || p.id_bad || p.id != DEV_ID_I) begin
                  d.st = S_IDLE;
                end else if (!(p.fcs_ok || (p.wild && PROTO_SEL_I != PROTO_NATIVE))) begin
                  ld        = build_frame(1'b1, DEV_ID_I, HDR_FRAME_ERR, '0, 5'h00);
                  load      = 1'b1;
                  d.fcs_err = 1'b1;
                end else if (p.len > DATA_MAX_LEN) begin
                  ld   = build_frame(1'b1, DEV_ID_I, HDR_CMD_ERR, '0, 5'h00);
                  load = 1'b1;
                end else begin
                  d.st   = S_CMD;
                  d.hdr  = p.hdr;
                  d.data = p.data;
                  d.len  = p.len;
                end
              end else begin
                if (q.cnt < PP_MIN_LEN) begin
                  d.st = S_IDLE;
                end else if (p.len > DATA_MAX_LEN) begin
                  ld   = build_frame(1'b0, DEV_ID_I, HDR_CMD_ERR, '0, 5'h00);
                  load = 1'b1;
                end else begin
                  d.st   = S_CMD;
                  d.hdr  = p.hdr;
                  d.data = p.data;
                  d.len  = p.len;
                end
              end
            end else begin
              // '*' not followed by return: drop the frame
              d.st = S_IDLE;
            end
          end else if (c == CH_STAR) begin
            d.star = 1'b1;
          end else if (q.cnt == RX_FULL) begin
            d.st = S_IDLE; // overlong frame is discarded silently
          end else begin
            d.rx[q.cnt] = c;
            d.cnt       = q.cnt + 5'h01;
            d.x         = q.x ^ c;
          end
        end
      end
      S_CMD: begin
        // user logic decides whether header and channel are valid
        if (RSP_VALID_I) begin
          if (RSP_OK_I) begin
            ld = build_frame(q.mp, DEV_ID_I, q.hdr, RSP_DATA_I, RSP_LEN_I);
          end else begin
            ld = build_frame(q.mp, DEV_ID_I, HDR_CMD_ERR, '0, 5'h00);
          end
          load = 1'b1;
        end
      end
      S_TX: begin
        if (link.d2h_ready) begin
          if (q.idx + 5'h01 == q.tx.len) begin
            // after an enquiry echo the next frame is unaddressed
            d.st      = q.pp_next ? S_RX : S_IDLE;
            d.mp      = 1'b0;
            d.star    = 1'b0;
            d.cnt     = 5'h00;
            d.x       = 8'h00;
            d.rx      = '0;
            d.pp_next = 1'b0;
          end else begin
            d.idx = q.idx + 5'h01;
            d.out = q.tx.chars[q.idx + 5'h01];
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
    // common start of any transmission
    if (load) begin
      d.st  = S_TX;
      d.tx  = ld;
      d.idx = 5'h00;
      d.out = ld.chars[0];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // receive is blocked while a command is pending or a reply goes out
  assign link.h2d_ready = (q.st == S_IDLE) || (q.st == S_RX);
  assign link.d2h_valid = (q.st == S_TX);
  assign link.d2h_data  = q.out;
  assign CMD_VALID_O    = (q.st == S_CMD);
  assign CMD_MP_O       = q.mp;
  assign CMD_HDR_O      = q.hdr;
  assign CMD_DATA_O     = q.data;
  assign CMD_LEN_O      = q.len;
  assign FCS_ERR_O      = q.fcs_err;

endmodule
`default_nettype wire

// ### verilog/hostlink_host.sv
// master end: sends command frames and collects and checks the replies
`timescale 1ns/1ps
`default_nettype none
module hostlink_host #(
  parameter int TIMEOUT_CYCLES = hostlink_pkg::RESP_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_N_I,
  // link towards the responding end
  hostlink_if.host                   link,
  // request from the user logic
  input  wire logic                  REQ_VALID_I,
  output logic                       REQ_READY_O,
  input  wire logic                  REQ_MP_I,
  input  wire logic [7:0]            REQ_ID_I,
  input  wire logic [15:0]           REQ_HDR_I,
  input  wire hostlink_pkg::data_t   REQ_DATA_I,
  input  wire logic [4:0]            REQ_LEN_I,
  input  wire logic                  REQ_WILD_I,
  // reply towards the user logic
  output logic                       RSP_VALID_O,
  output logic [15:0]                RSP_HDR_O,
  output hostlink_pkg::data_t        RSP_DATA_O,
  output logic [4:0]                 RSP_LEN_O,
  output logic                       RSP_FCS_ERR_O,
  output logic                       RSP_ID_ERR_O,
  output logic                       RSP_FRAME_ERR_O,
  output logic                       RSP_CMD_ERR_O,
  output logic                       RSP_TIMEOUT_O
);
  import hostlink_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_ENQ, H_WECHO, H_SEND, H_RESP} hstate_t;

  typedef struct packed {
    hstate_t     st;
    logic        mp;
    logic [7:0]  id;
    frame_t      tx;
    logic [4:0]  idx;
    logic [7:0]  out;
    rxbuf_t      rx;
    logic [4:0]  cnt;
    logic [7:0]  x;
    logic        star;
    logic [31:0] tmo;
    logic        rvalid;
    logic [15:0] hdr;
    data_t       data;
    logic [4:0]  len;
    logic        fcs_err;
    logic        id_err;
    logic        tmo_err;
  } host_t;

  host_t      q;
  host_t      d;
  parsed_t    p;
  logic [7:0] c;
  logic       done;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d        = q;
    d.rvalid = 1'b0;
    done     = 1'b0;
    c        = link.d2h_data;
    p        = parse_frame(q.rx, q.cnt, q.x, q.mp);
    case (q.st)
      H_IDLE: begin
        if (REQ_VALID_I) begin
          d.mp  = REQ_MP_I;
          d.id  = REQ_ID_I;
          d.tx  = build_frame(REQ_MP_I, REQ_ID_I, REQ_HDR_I, REQ_DATA_I, REQ_LEN_I);
          if (REQ_MP_I && REQ_WILD_I) begin
            d.tx.chars[d.tx.len - FCS_FROM_END]         = CH_ZERO;
            d.tx.chars[d.tx.len - FCS_FROM_END + 5'h01] = CH_ZERO;
          end
          d.idx = 5'h00;
          // multi-point goes out directly, point-to-point asks first
          d.out = REQ_MP_I ? d.tx.chars[0] : CH_ENQ;
          d.st  = REQ_MP_I ? H_SEND : H_ENQ;
          d.tmo = 32'h0;
        end
      end
      H_ENQ: begin
        if (link.h2d_ready) d.st = H_WECHO;
      end
      H_WECHO: begin
        d.tmo = q.tmo + 32'h1;
        if (link.d2h_valid && c == CH_ENQ) begin
          d.st  = H_SEND;
          d.out = q.tx.chars[0];
        end else if (q.tmo == 32'(TIMEOUT_CYCLES)) begin
          done = 1'b1;
        end
      end
      H_SEND: begin
        if (link.h2d_ready) begin
          if (q.idx + 5'h01 == q.tx.len) begin
            d.st   = H_RESP;
            d.cnt  = 5'h00;
            d.x    = 8'h00;
            d.star = 1'b0;
            d.rx   = '0;
            d.tmo  = 32'h0;
          end else begin
            d.idx = q.idx + 5'h01;
            d.out = q.tx.chars[q.idx + 5'h01];
          end
        end
      end
      H_RESP: begin
        d.tmo = q.tmo + 32'h1;
        if (link.d2h_valid) begin
          if (q.star) begin
            // reply complete: check id, check byte and error headers
            d.rvalid  = 1'b1;
            d.hdr     = p.hdr;
            d.data    = p.data;
            d.len     = (p.len > DATA_MAX_LEN) ? DATA_MAX_LEN : p.len;
            d.fcs_err = q.mp && !p.fcs_ok;
            d.id_err  = q.mp && (p.id_bad || p.id != q.id || q.rx[0] != CH_AT);
            d.tmo_err = 1'b0;
            d.st      = H_IDLE;
          end else if (c == CH_STAR) begin
            d.star = 1'b1;
          end else if (q.cnt != RX_FULL) begin
            d.rx[q.cnt] = c;
            d.cnt       = q.cnt + 5'h01;
            d.x         = q.x ^ c;
          end
        end else if (q.tmo == 32'(TIMEOUT_CYCLES)) begin
          // a silent line means no node carries this id
          done = 1'b1;
        end
      end
      default: d.st = H_IDLE;
    endcase
    if (done) begin
      d.rvalid  = 1'b1;
      d.tmo_err = 1'b1;
      d.fcs_err = 1'b0;
      d.id_err  = 1'b0;
      d.hdr     = 16'h0000;
      d.len     = 5'h00;
      d.st      = H_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign REQ_READY_O     = (q.st == H_IDLE);
  assign link.h2d_valid  = (q.st == H_ENQ) || (q.st == H_SEND);
  assign link.h2d_data   = q.out;
  assign link.d2h_ready  = (q.st == H_WECHO) || (q.st == H_RESP);
  assign RSP_VALID_O     = q.rvalid;
  assign RSP_HDR_O       = q.hdr;
  assign RSP_DATA_O      = q.data;
  assign RSP_LEN_O       = q.len;
  assign RSP_FCS_ERR_O   = q.fcs_err;
  assign RSP_ID_ERR_O    = q.id_err;
  assign RSP_FRAME_ERR_O = (q.hdr == HDR_FRAME_ERR);
  assign RSP_CMD_ERR_O   = (q.hdr == HDR_CMD_ERR);
  assign RSP_TIMEOUT_O   = q.tmo_err;

endmodule
`default_nettype wire

// ### testbench/hostlink_checker.sv
// link-level assertions watching the joined host and device ends
`timescale 1ns/1ps
`default_nettype none
module hostlink_checker (
  // clock and reset
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  // link signals
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  import hostlink_pkg::*;
  // ---------------------------------------------------------------
  // one clock domain, so clocking and disable are set once
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // a character moves only on valid and ready together
  wire logic h_take = h2d_valid & h2d_ready;
  wire logic d_take = d2h_valid & d2h_ready;

  property p_h2d_hold;
    h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data);
  endproperty
  property p_d2h_hold;
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data);
  endproperty
  property p_enq_echo;
    h_take && h2d_data == CH_ENQ |=> d2h_valid && d2h_data == CH_ENQ;
  endproperty
  property p_echo_once;
    d_take && d2h_data == CH_ENQ |=> !d2h_valid;
  endproperty
  property p_no_at_after_enq;
    h_take && h2d_data == CH_ENQ |=> !(h2d_valid && h2d_data == CH_AT) [*4];
  endproperty
  property p_star_cr;
    d_take && d2h_data == CH_STAR |=> d2h_valid && d2h_data == CH_CR;
  endproperty
  property p_cr_end;
    d_take && d2h_data == CH_CR |=> !d2h_valid [*2];
  endproperty
  // half duplex: the host is silent while the device answers
  property p_quiet;
    d2h_valid |-> !h2d_valid;
  endproperty
  property p_id_hex;
    d_take && d2h_data == CH_AT |=> d2h_valid &&
      (d2h_data inside {[CH_ZERO:CH_NINE], [CH_A:CH_F]});
  endproperty

  a_h2d_hold: assert property (p_h2d_hold) else $error("host char changed early");
  a_d2h_hold: assert property (p_d2h_hold) else $error("reply char changed early");
  a_enq_echo: assert property (p_enq_echo) else $error("enquiry not echoed");
  a_echo_once: assert property (p_echo_once) else $error("echo too long");
  a_no_at_after_enq: assert property (p_no_at_after_enq) else $error("at after enq");
  a_star_cr: assert property (p_star_cr) else $error("star without cr");
  a_cr_end: assert property (p_cr_end) else $error("reply goes on after cr");
  a_quiet: assert property (p_quiet) else $error("both ends talking");
  a_id_hex: assert property (p_id_hex) else $error("reply id not hex");
  c_enq: cover property (h_take && h2d_data == CH_ENQ);
  c_at: cover property (h_take && h2d_data == CH_AT);
  c_cr: cover property (d_take && d2h_data == CH_CR);
endmodule
`default_nettype wire

// ### testbench/tb_multipoint_host_link_framer.sv
// bench joining both link ends, driven through their user sides
`timescale 1ns/1ps
`default_nettype none
module tb_multipoint_host_link_framer;
  import hostlink_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam data_t   REQ_DAT = 64'h3736353433323130;
  localparam data_t   RSP_DAT = 64'h4645444342413938;
  logic               clk, rst_n, req_valid, req_ready, req_mp, req_wild;
  logic               cmd_valid, cmd_mp, fcs_err, rsp_valid, rsp_ok;
  logic               rsp_v, f_err, fr_err, c_err, t_o, i_err;
  logic [7:0]         dev_id, req_id;
  logic [3:0]         proto;
  logic [15:0]        cmd_hdr, hdr_o;
  logic [4:0]         cmd_len, rsp_len, req_len, len_o;
  data_t              cmd_data, data_o;
  int                 error_cnt, tests_run, cmd_cnt, fe_cnt;

  hostlink_if u_hostlink_if ();
  hostlink_device u_hostlink_device (.CLK_I(clk), .RST_N_I(rst_n), .DEV_ID_I(dev_id),
    .PROTO_SEL_I(proto), .link(u_hostlink_if), .CMD_VALID_O(cmd_valid), .CMD_MP_O(cmd_mp),
    .CMD_HDR_O(cmd_hdr), .CMD_DATA_O(cmd_data), .CMD_LEN_O(cmd_len), .RSP_VALID_I(rsp_valid),
    .RSP_OK_I(rsp_ok), .RSP_DATA_I(RSP_DAT), .RSP_LEN_I(rsp_len), .FCS_ERR_O(fcs_err));
  hostlink_host #(.TIMEOUT_CYCLES(200)) u_hostlink_host (.CLK_I(clk), .RST_N_I(rst_n),
    .link(u_hostlink_if), .REQ_VALID_I(req_valid), .REQ_READY_O(req_ready), .REQ_MP_I(req_mp),
    .REQ_ID_I(req_id), .REQ_HDR_I(16'h5249), .REQ_DATA_I(REQ_DAT), .REQ_LEN_I(req_len),
    .REQ_WILD_I(req_wild), .RSP_VALID_O(rsp_v), .RSP_HDR_O(hdr_o), .RSP_DATA_O(data_o),
    .RSP_LEN_O(len_o), .RSP_FCS_ERR_O(f_err), .RSP_ID_ERR_O(i_err), .RSP_FRAME_ERR_O(fr_err),
    .RSP_CMD_ERR_O(c_err), .RSP_TIMEOUT_O(t_o));
  hostlink_checker u_hostlink_checker (.CLK_I(clk), .RST_N_I(rst_n),
    .h2d_data(u_hostlink_if.h2d_data), .h2d_valid(u_hostlink_if.h2d_valid),
    .h2d_ready(u_hostlink_if.h2d_ready), .d2h_data(u_hostlink_if.d2h_data),
    .d2h_valid(u_hostlink_if.d2h_valid), .d2h_ready(u_hostlink_if.d2h_ready));

  // ---------------------------------------------------------------
  // compare, verdict and user-side responder
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // answers every decoded command with a one-cycle pulse
  always @(posedge clk) begin
    #1;
    if (cmd_valid === 1'b1 && rsp_valid === 1'b0) begin
      cmd_cnt++;
      chk(cmd_hdr, 16'h5249);
      chk(cmd_mp, req_mp);
      chk(cmd_len, req_len);
      if (req_len != 5'h00) chk(cmd_data[0], 8'h30);
    end
    rsp_valid = (cmd_valid === 1'b1) && (rsp_valid === 1'b0);
  end

  // one-cycle registered pulse, sampled mid-cycle where it has settled
  always @(negedge clk) begin
    if (fcs_err === 1'b1) fe_cnt++;
  end

  // kind: 0 normal reply, 1 framing error, 2 command error, 3 silence
  task automatic run(input logic mp, input logic [7:0] id, input logic wild,
                     input logic [3:0] ps, input logic ok, input logic [4:0] len, input int kind);
    int n0;
    int f0;
    int k;
    n0 = cmd_cnt;
    f0 = fe_cnt;
    k = 0;
    proto = ps;
    rsp_ok = ok;
    rsp_len = len;
    req_mp = mp;
    req_id = id;
    req_wild = wild;
    req_len = len;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && k < 50) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(req_ready, 1'b1);
    @(posedge clk);
    #1 req_valid = 1'b0;
    k = 0;
    while (rsp_v !== 1'b1 && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(rsp_v, 1'b1);
    chk(t_o, kind == 3);
    chk(cmd_cnt - n0, kind == 0 || kind == 2);
    chk(fe_cnt - f0, kind == 1);
    chk(fr_err, kind == 1);
    chk(c_err, kind == 2);
    if (kind != 3) chk(f_err, 1'b0);
    if (kind != 3) chk(i_err, 1'b0);
    if (kind != 3) chk(hdr_o, kind == 0 ? 16'h5249 : kind == 1 ? HDR_FRAME_ERR : HDR_CMD_ERR);
    if (kind == 0) chk(len_o, len);
    if (kind == 0 && len != 5'h00) chk(data_o[0], 8'h38);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and the main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the sequence needs well under 1000 cycles, so 10000 leave ample margin
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    {rst_n, req_valid, req_mp, req_wild, rsp_valid, rsp_ok} = 6'h00;
    {error_cnt, tests_run, cmd_cnt, fe_cnt} = '0;
    {dev_id, req_id, proto, rsp_len, req_len} = {8'h5A, 8'h00, 4'h0, 5'h00, 5'h00};
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    run(1'b1, 8'h5A, 1'b0, 4'h0, 1'b1, 5'h03, 0);
    run(1'b1, 8'h5A, 1'b1, 4'h0, 1'b1, 5'h00, 0);
    run(1'b1, 8'h5A, 1'b1, PROTO_NATIVE, 1'b1, 5'h02, 1);
    run(1'b1, 8'hA5, 1'b0, 4'h0, 1'b1, 5'h02, 3);
    run(1'b0, 8'h00, 1'b0, 4'h0, 1'b1, 5'h01, 0);
    run(1'b1, 8'h5A, 1'b0, 4'h0, 1'b0, 5'h01, 2);
    run(1'b1, 8'h5A, 1'b0, PROTO_NATIVE, 1'b1, 5'h08, 0);
    dev_id = 8'hFF;
    run(1'b1, 8'hFF, 1'b0, 4'h0, 1'b1, 5'h01, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
